//--- rtl/tcp_deadtime.sv
`timescale 1ns/10ps
module tcp_deadtime
  import tcp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ref,
  input wire logic [7:0] i_deadtime,
  input wire logic i_moe,
  input wire tcp_outcfg_type i_cfg,
  output logic o_main,
  output logic o_compl
);
  tcp_dtg_state_type r;
  tcp_dtg_state_type next_r;
  logic both;
  logic act_main;
  logic act_compl;
  logic done;

  always_comb begin
    next_r = r;
    both = i_cfg.main_en & i_cfg.compl_en;
    if (i_moe) begin
      act_main = i_cfg.main_en & i_ref;
      act_compl = i_cfg.compl_en & (both ? ~i_ref : i_ref); // RL24
    end else begin
      act_main = i_cfg.main_idle ^ i_cfg.main_pol; // RL22
      act_compl = i_cfg.compl_idle ^ i_cfg.compl_pol; // RL22
    end
    if ((act_main != r.want_main) || (act_compl != r.want_compl)) begin
      next_r.cnt = 8'h00; // RL26
    end else if (r.cnt != TCP_DT_SAT) begin
      next_r.cnt = r.cnt + 8'h01; // RL26
    end
    next_r.want_main = act_main;
    next_r.want_compl = act_compl;
    done = both ? (next_r.cnt >= i_deadtime) : 1'b1; // RL18 RL19
    next_r.main = (act_main & done) ^ i_cfg.main_pol; // RL20 RL21 RL17
    next_r.compl = (act_compl & done) ^ i_cfg.compl_pol; // RL20 RL21 RL17
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_main = r.main;
  assign o_compl = r.compl;

  a_dead_gap: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL20
    ($rose(i_ref) && i_moe && both && !i_cfg.main_pol && i_deadtime > 8'h01 && $stable(i_deadtime))
    |=> !o_main) else $error("Main output rose without dead time.");
  a_no_overlap: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL21
    (i_moe && both && !i_cfg.main_pol && !i_cfg.compl_pol && $stable(i_moe) && $stable(i_cfg))
    |=> !(o_main && o_compl)) else $error("Main and complementary outputs both active.");
endmodule : tcp_deadtime

//--- rtl/tcp_pkg.sv
package tcp_pkg;
  localparam int TCP_NCH = 4;
  localparam int TCP_CW = 16;
  localparam logic [7:0] TCP_CTRL = 8'h00;
  localparam logic [7:0] TCP_EVENT = 8'h04;
  localparam logic [7:0] TCP_STATUS = 8'h08;
  localparam logic [7:0] TCP_IRQEN = 8'h0C;
  localparam logic [7:0] TCP_COUNT = 8'h10;
  localparam logic [7:0] TCP_RELOAD = 8'h14;
  localparam logic [7:0] TCP_CHMODE = 8'h18;
  localparam logic [7:0] TCP_OUTCFG = 8'h1C;
  localparam logic [7:0] TCP_DEADTIME = 8'h20;
  localparam logic [7:0] TCP_CMP0 = 8'h24;
  localparam int TCP_B_RUN = 0;
  localparam int TCP_B_DIR = 1;
  localparam int TCP_B_CMS = 2;
  localparam int TCP_B_RELOAD_PRELOAD_EN = 4;
  localparam int TCP_B_MOE = 5;
  localparam int TCP_B_UG = 0;
  localparam int TCP_CHMODE_W = 4;
  localparam int TCP_OUTCFG_W = 6;
  localparam logic [15:0] TCP_RELOAD_RST = 16'hFFFF;
  localparam logic [2:0] TCP_OC_FROZEN = 3'h0;
  localparam logic [2:0] TCP_OC_ACTIVE = 3'h1;
  localparam logic [2:0] TCP_OC_INACTIVE = 3'h2;
  localparam logic [2:0] TCP_OC_TOGGLE = 3'h3;
  localparam logic [2:0] TCP_OC_FORCE_LO = 3'h4;
  localparam logic [2:0] TCP_OC_FORCE_HI = 3'h5;
  localparam logic [2:0] TCP_OC_PWM1 = 3'h6;
  localparam logic [2:0] TCP_OC_PWM2 = 3'h7;
  localparam logic [1:0] TCP_CMS_EDGE = 2'h0;
  localparam logic [1:0] TCP_CMS_DOWN = 2'h1;
  localparam logic [1:0] TCP_CMS_UP = 2'h2;
  localparam logic [7:0] TCP_DT_SAT = 8'hFF;

  typedef enum logic [1:0] {
    TCP_BUS_IDLE = 2'b00,
    TCP_BUS_WRITE = 2'b01,
    TCP_BUS_READ = 2'b10
  } tcp_bus_type;

  typedef struct packed {
    logic main_en;
    logic main_pol;
    logic compl_en;
    logic compl_pol;
    logic main_idle;
    logic compl_idle;
  } tcp_outcfg_type;

  typedef struct packed {
    logic [7:0] cnt;
    logic want_main;
    logic want_compl;
    logic main;
    logic compl;
  } tcp_dtg_state_type;
endpackage : tcp_pkg

//--- rtl/tcp_timer_channel.sv
`timescale 1ns/10ps
// Summary of operation
// RL1 - On match, mode 000 holds, 001 sets, 010 clears, 011 toggles the reference.
// RL2 - Each match sets the channel flag; the request rises only when enabled.
// RL3 - In output compare modes the update event leaves the reference alone.
// RL4 - Reference changes on the very count that matches.
// RL5 - Compare writes act at once, or at next update when preload is on.
// RL6 - Mode 110 is PWM 1 and 111 is PWM 2, per channel.
// RL7 - Period follows reload, duty follows compare, compared every count.
// RL8 - Shadows load from preload only on an update; software forces one first.
// RL9 - PWM 1 counting up: high while counter is below compare.
// RL10 - Compare above reload keeps it high; compare zero keeps it low.
// RL11 - PWM 1 counting down: low while counter exceeds compare, else high.
// RL12 - Any nonzero center select counts center aligned; it picks flag direction.
// RL13 - Center select 01 sets flags only while counting down.
// RL14 - Hardware owns the direction bit in center-aligned counting.
// RL15 - Center counting starts in the held direction; don't write both fields together.
// RL16 - Counter write above reload keeps direction; zero or reload sets it, no update.
// RL17 - Main and complementary polarity are chosen independently.
// RL18 - Dead time works only with both output enables and master enable.
// RL19 - One eight-bit dead-time field serves every channel.
// RL20 - Main delays the reference rise; complementary delays its inverted rise.
// RL21 - Pulses shorter than the dead time are dropped.
// RL22 - Dead time is also inserted when master enable falls to idle.
// RL23 - Mode 101 forces reference high, 100 low; flags keep working.
// RL24 - Complementary alone follows the reference uninverted.
// RL25 - PWM 2 is the inverse of PWM 1.
// RL26 - Dead time counts one kernel clock per setting step.
module tcp_timer_channel
  import tcp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [TCP_NCH-1:0] o_main_output,
  output logic [TCP_NCH-1:0] o_compl_output,
  output logic o_match_irq
);
  typedef struct packed {
    tcp_bus_type phase;
    logic [7:0] waddr;
    logic [31:0] rdata;
    logic ready;
    logic run;
    logic dir;
    logic [1:0] center_align_sel;
    logic reload_preload_en;
    logic master_out_en;
    logic [TCP_CW-1:0] cnt;
    logic [TCP_CW-1:0] arr_pre;
    logic [TCP_CW-1:0] arr;
    logic [TCP_NCH-1:0][2:0] mode;
    logic [TCP_NCH-1:0] ocpe;
    logic [TCP_NCH-1:0] flag;
    logic [TCP_NCH-1:0] irq_en;
    logic [TCP_NCH-1:0] ref_wave;
    logic [TCP_NCH-1:0][TCP_CW-1:0] ccr_pre;
    logic [TCP_NCH-1:0][TCP_CW-1:0] ccr;
    tcp_outcfg_type [TCP_NCH-1:0] ocfg;
    logic [7:0] dt;
    logic irq;
  } tcp_state_type;

  tcp_state_type r;
  tcp_state_type next_r;
  logic wr;
  logic update_event;
  logic [TCP_NCH-1:0] hit;
  logic [TCP_NCH-1:0] hit_flag;
  logic [TCP_NCH-1:0] wr_cmp;
  logic [TCP_CW-1:0] wval;

  function automatic logic [31:0] read_reg(input tcp_state_type s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      TCP_CTRL: d[5:0] = {s.master_out_en, s.reload_preload_en, s.center_align_sel, s.dir, s.run};
      TCP_STATUS: d[TCP_NCH-1:0] = s.flag;
      TCP_IRQEN: d[TCP_NCH-1:0] = s.irq_en;
      TCP_COUNT: d[TCP_CW-1:0] = s.cnt;
      TCP_RELOAD: d[TCP_CW-1:0] = s.arr_pre;
      TCP_DEADTIME: d[7:0] = s.dt;
      default: d = 32'h0000_0000;
    endcase
    for (int i = 0; i < TCP_NCH; i++) begin
      d[i*TCP_CHMODE_W +: TCP_CHMODE_W] = (a == TCP_CHMODE) ? {s.ocpe[i], s.mode[i]}
        : d[i*TCP_CHMODE_W +: TCP_CHMODE_W];
      d[i*TCP_OUTCFG_W +: TCP_OUTCFG_W] = (a == TCP_OUTCFG) ? s.ocfg[i]
        : d[i*TCP_OUTCFG_W +: TCP_OUTCFG_W];
      if (a == TCP_CMP0 + 8'(4 * i)) begin
        d[TCP_CW-1:0] = s.ccr_pre[i];
      end
    end
    return d;
  endfunction : read_reg

  always_comb begin
    next_r = r;
    next_r.ready = 1'b1;
    wr = (r.phase == TCP_BUS_WRITE);
    wval = hwdata[TCP_CW-1:0];
    update_event = 1'b0;
    hit = '0;
    hit_flag = '0;
    wr_cmp = '0;
    if (hsel && htrans[1] && hready) begin
      next_r.phase = hwrite ? TCP_BUS_WRITE : TCP_BUS_READ;
      next_r.waddr = {haddr[7:2], 2'b00};
      next_r.rdata = hwrite ? 32'h0000_0000 : read_reg(r, {haddr[7:2], 2'b00});
    end else begin
      next_r.phase = TCP_BUS_IDLE;
    end

    if (r.run) begin
      if (r.center_align_sel == TCP_CMS_EDGE) begin
        if (!r.dir) begin
          if (r.cnt >= r.arr) begin
            next_r.cnt = '0;
            update_event = 1'b1;
          end else begin
            next_r.cnt = r.cnt + 1'b1;
          end
        end else if (r.cnt == '0) begin
          next_r.cnt = r.arr;
          update_event = 1'b1;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end else if (!r.dir) begin
        if (r.cnt >= r.arr) begin
          next_r.dir = 1'b1; // RL14
          next_r.cnt = r.cnt - 1'b1;
          update_event = 1'b1;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end else if (r.cnt == '0) begin
        next_r.dir = 1'b0; // RL14
        next_r.cnt = {{(TCP_CW-1){1'b0}}, 1'b1};
        update_event = 1'b1;
      end else begin
        next_r.cnt = r.cnt - 1'b1;
      end
    end

    if (wr) begin
      case (r.waddr)
        TCP_CTRL: begin
          next_r.run = hwdata[TCP_B_RUN];
          next_r.center_align_sel = hwdata[TCP_B_CMS +: 2];
          next_r.reload_preload_en = hwdata[TCP_B_RELOAD_PRELOAD_EN];
          next_r.master_out_en = hwdata[TCP_B_MOE];
          if (r.center_align_sel == TCP_CMS_EDGE) begin
            next_r.dir = hwdata[TCP_B_DIR]; // RL14 RL15
          end
        end
        TCP_EVENT: begin
          if (hwdata[TCP_B_UG]) begin
            update_event = 1'b1; // RL8
            next_r.cnt = (r.center_align_sel == TCP_CMS_EDGE && r.dir) ? r.arr_pre : '0;
          end
        end
        TCP_IRQEN: next_r.irq_en = hwdata[TCP_NCH-1:0];
        TCP_COUNT: begin
          next_r.cnt = wval;
          if (r.center_align_sel != TCP_CMS_EDGE && wval == '0) begin
            next_r.dir = 1'b0; // RL16
          end else if (r.center_align_sel != TCP_CMS_EDGE && wval == r.arr) begin
            next_r.dir = 1'b1; // RL16
          end
        end
        TCP_RELOAD: begin
          next_r.arr_pre = wval;
          if (!r.reload_preload_en) begin
            next_r.arr = wval;
          end
        end
        TCP_DEADTIME: next_r.dt = hwdata[7:0]; // RL19
        default: next_r.dt = r.dt;
      endcase
    end

    for (int i = 0; i < TCP_NCH; i++) begin
      if (wr && r.waddr == TCP_CHMODE) begin
        {next_r.ocpe[i], next_r.mode[i]} = hwdata[i*TCP_CHMODE_W +: TCP_CHMODE_W]; // RL6
      end
      if (wr && r.waddr == TCP_OUTCFG) begin
        next_r.ocfg[i] = hwdata[i*TCP_OUTCFG_W +: TCP_OUTCFG_W]; // RL17
      end
      wr_cmp[i] = wr && (r.waddr == TCP_CMP0 + 8'(4 * i));
      if (wr_cmp[i]) begin
        next_r.ccr_pre[i] = wval;
        if (!r.ocpe[i]) begin
          next_r.ccr[i] = wval; // RL5
        end
      end
      if (update_event) begin
        next_r.ccr[i] = next_r.ccr_pre[i]; // RL5 RL8
      end
    end
    if (update_event) begin
      next_r.arr = next_r.arr_pre; // RL8
    end

    for (int i = 0; i < TCP_NCH; i++) begin
      hit[i] = r.run && (next_r.cnt == next_r.ccr[i]); // RL4 RL7
      case (r.center_align_sel)
        TCP_CMS_EDGE: hit_flag[i] = hit[i];
        TCP_CMS_DOWN: hit_flag[i] = hit[i] && r.dir; // RL13
        TCP_CMS_UP: hit_flag[i] = hit[i] && !r.dir; // RL12
        default: hit_flag[i] = hit[i]; // RL12
      endcase
      if (wr && r.waddr == TCP_STATUS) begin
        next_r.flag[i] = (r.flag[i] & hwdata[i]) | hit_flag[i]; // RL2
      end else begin
        next_r.flag[i] = r.flag[i] | hit_flag[i]; // RL2
      end
      case (next_r.mode[i])
        TCP_OC_FROZEN: next_r.ref_wave[i] = r.ref_wave[i]; // RL1 RL3
        TCP_OC_ACTIVE: next_r.ref_wave[i] = hit[i] | r.ref_wave[i]; // RL1
        TCP_OC_INACTIVE: next_r.ref_wave[i] = !hit[i] & r.ref_wave[i]; // RL1
        TCP_OC_TOGGLE: next_r.ref_wave[i] = hit[i] ^ r.ref_wave[i]; // RL1
        TCP_OC_FORCE_LO: next_r.ref_wave[i] = 1'b0; // RL23
        TCP_OC_FORCE_HI: next_r.ref_wave[i] = 1'b1; // RL23
        TCP_OC_PWM1: next_r.ref_wave[i] = next_r.dir ? (next_r.cnt <= next_r.ccr[i])
          : (next_r.cnt < next_r.ccr[i]); // RL9 RL10 RL11
        TCP_OC_PWM2: next_r.ref_wave[i] = next_r.dir ? !(next_r.cnt <= next_r.ccr[i])
          : !(next_r.cnt < next_r.ccr[i]); // RL25
        default: next_r.ref_wave[i] = r.ref_wave[i];
      endcase
    end
    next_r.irq = |(next_r.flag & next_r.irq_en); // RL2
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      r <= '0;
      r.arr_pre <= TCP_RELOAD_RST;
      r.arr <= TCP_RELOAD_RST;
    end else begin
      r <= next_r;
    end
  end

  for (genvar g = 0; g < TCP_NCH; g++) begin : g_ch
    tcp_deadtime u_dt (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_ref(r.ref_wave[g]),
      .i_deadtime(r.dt),
      .i_moe(r.master_out_en),
      .i_cfg(r.ocfg[g]),
      .o_main(o_main_output[g]),
      .o_compl(o_compl_output[g])
    );
  end

  assign hrdata = r.rdata;
  assign hreadyout = r.ready;
  assign hresp = 1'b0;
  assign o_match_irq = r.irq;

  a_flag_set: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL2
    hit_flag[0] |=> r.flag[0]) else $error("Match did not set the flag.");
  a_irq_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL2
    o_match_irq == |(r.flag & r.irq_en)) else $error("Request does not follow enabled flags.");
  a_center_down: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL13
    (r.center_align_sel == TCP_CMS_DOWN && !r.dir && !(wr && r.waddr == TCP_STATUS)) |-> !hit_flag[0])
    else $error("Flag raised while counting up in down-only center mode.");
  a_match_set: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL1
    (hit[0] && next_r.mode[0] == TCP_OC_ACTIVE) |=> r.ref_wave[0])
    else $error("Active-on-match did not drive reference high.");
  a_match_toggle: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL1
    (hit[0] && r.mode[0] == TCP_OC_TOGGLE && next_r.mode[0] == TCP_OC_TOGGLE)
    |=> r.ref_wave[0] != $past(r.ref_wave[0])) else $error("Toggle-on-match did not toggle.");
  a_oc_uev: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL3
    (update_event && !hit[0] && r.mode[0] < TCP_OC_FORCE_LO && next_r.mode[0] == r.mode[0])
    |=> $stable(r.ref_wave[0])) else $error("Update event moved an output compare reference.");
  a_pwm1_up: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL9
    (r.mode[0] == TCP_OC_PWM1 && !r.dir) |-> r.ref_wave[0] == (r.cnt < r.ccr[0]))
    else $error("PWM 1 upcount level wrong.");
  a_pwm1_down: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL11
    (r.mode[0] == TCP_OC_PWM1 && r.dir && r.cnt > r.ccr[0]) |-> !r.ref_wave[0])
    else $error("PWM 1 downcount level wrong.");
  a_pwm2_inv: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL25
    (r.mode[0] == TCP_OC_PWM2 && !r.dir) |-> r.ref_wave[0] == (r.cnt >= r.ccr[0]))
    else $error("PWM 2 is not the inverse of PWM 1.");
  a_preload_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL5
    (wr_cmp[0] && r.ocpe[0] && !update_event) |=> r.ccr[0] == $past(r.ccr[0]))
    else $error("Preloaded compare reached the shadow without update.");
  a_forced_hi: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RL23
    (r.mode[0] == TCP_OC_FORCE_HI) |-> r.ref_wave[0]) else $error("Forced high not held.");
endmodule : tcp_timer_channel

//--- verification/tcp_switch_model.sv
`timescale 1ns/10ps
// Power stage on the far side: a high-side and a low-side switch per channel.
// It counts the cycles in which both switches of a channel conduct while watched.
module tcp_switch_model
  import tcp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_watch,
  input wire logic [TCP_NCH-1:0] i_high_side,
  input wire logic [TCP_NCH-1:0] i_low_side,
  input wire logic [TCP_NCH-1:0] i_high_act_low,
  input wire logic [TCP_NCH-1:0] i_low_act_low,
  output logic [31:0] o_overlap
);
  logic [TCP_NCH-1:0] on_high;
  logic [TCP_NCH-1:0] on_low;
  assign on_high = i_high_side ^ i_high_act_low;
  assign on_low = i_low_side ^ i_low_act_low;
  initial o_overlap = 32'h0000_0000;
  always @(posedge i_ref_clk) begin
    if (i_watch && ((on_high & on_low) !== 4'h0)) begin
      o_overlap <= o_overlap + 32'h0000_0001;
    end
  end
endmodule : tcp_switch_model

//--- verification/timer_compare_pwm_deadtime_tb_top.sv
`timescale 1ns/10ps
`define TCP_CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, s); end end
module timer_compare_pwm_deadtime_tb_top;
  import tcp_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [TCP_NCH-1:0] o_main_output;
  logic [TCP_NCH-1:0] o_compl_output;
  logic o_match_irq;
  logic rd_phase = 1'b0;
  logic [3:0] act_low = 4'h0;
  logic [31:0] ovl;
  int n_errors = 0;
  int checks = 0;
  int meas_n = 0;
  int cnt [9];
  int em [9];
  int c [4];
  int seed = 32'h3b4e_bd33;
  logic [31:0] exp_q [$];
  string nm_q [$];

  initial forever #5 i_ref_clk = ~i_ref_clk;

  tcp_timer_channel tcp_timer_channel_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .o_main_output(o_main_output), .o_compl_output(o_compl_output),
    .o_match_irq(o_match_irq));

  tcp_switch_model tcp_switch_model_i (.i_ref_clk(i_ref_clk), .i_watch(meas_n > 0), .i_high_side(o_main_output),
    .i_low_side(o_compl_output), .i_high_act_low(act_low), .i_low_act_low(4'h0), .o_overlap(ovl));

  function automatic int lvl(input logic b);
    return (b === 1'b1) ? 1 : ((b === 1'b0) ? 0 : 9999);
  endfunction : lvl

  function automatic int hi1(input int cv, input int r);
    return (cv > r) ? r + 1 : cv;
  endfunction : hi1

  task automatic give_verdict();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check_one(input logic [31:0] seen);
    logic [31:0] e;
    string nm;
    e = exp_q.pop_front();
    nm = nm_q.pop_front();
    `TCP_CHK(nm, e, seen)
  endtask : check_one

  // Results are compared here as they appear: read data and counted pin levels.
  always @(posedge i_ref_clk) begin
    if (rd_phase && hreadyout === 1'b1) begin
      check_one(hrdata);
    end
    if (meas_n > 0) begin
      for (int i = 0; i < 4; i++) begin
        cnt[i] += lvl(o_main_output[i]);
        cnt[i + 4] += lvl(o_compl_output[i]);
      end
      cnt[8] += lvl(o_match_irq);
      meas_n--;
      if (meas_n == 0) begin
        for (int i = 0; i < 9; i++) begin
          check_one(cnt[i]);
        end
      end
    end
  end

  task automatic wait_ready();
    int t;
    t = 0;
    @(posedge i_ref_clk);
    while (hreadyout !== 1'b1 && t < 100) begin
      t++;
      @(posedge i_ref_clk);
    end
    if (t >= 100) begin
      n_errors++;
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_phase <= ~wr;
    wait_ready();
    rd_phase <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Counts high cycles of every pin and the request over n cycles against em.
  task automatic measure(input int n);
    for (int i = 0; i < 9; i++) begin
      exp_q.push_back(em[i]);
      nm_q.push_back($sformatf("pin%0d", i));
      cnt[i] = 0;
    end
    meas_n <= n;
    @(posedge i_ref_clk);
    while (meas_n > 0) begin
      @(posedge i_ref_clk);
    end
  endtask : measure

  task automatic set_cmp();
    for (int i = 0; i < 4; i++) begin
      wr(8'(TCP_CMP0 + 4 * i), 32'(c[i]));
    end
  endtask : set_cmp

  initial begin
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 1'b0;
  end

  initial begin
    repeat (5000) @(posedge i_ref_clk);
    n_errors++;
    give_verdict();
  end

  initial begin
    em = '{0, 0, 0, 0, 0, 0, 0, 0, 0};
    @(posedge i_ref_clk);
    measure(4);
    @(posedge i_ref_clk);
    rd(TCP_RELOAD, 32'h0000_FFFF, "reload");
    rd(8'h3C, 32'h0000_0000, "unmapped");
    rd(TCP_EVENT, 32'h0000_0000, "event");
    // Output compare: toggle, active, inactive and frozen, one per channel.
    wr(TCP_RELOAD, 32'h0000_0007);
    c = '{3, 3, 3, 3};
    set_cmp();
    wr(TCP_CHMODE, 32'h0000_0213);
    wr(TCP_OUTCFG, 32'({4{6'b100000}}));
    wr(TCP_CTRL, 32'h0000_0020);
    wr(TCP_EVENT, 32'h0000_0001);
    wr(TCP_CTRL, 32'h0000_0021);
    repeat (16) @(posedge i_ref_clk);
    em = '{8, 16, 0, 0, 0, 0, 0, 0, 0};
    measure(16);
    wr(TCP_STATUS, 32'h0000_0000);
    repeat (8) @(posedge i_ref_clk);
    rd(TCP_STATUS, 32'h0000_000F, "flags");
    wr(TCP_CTRL, 32'h0000_0020);
    wr(TCP_OUTCFG, 32'h0000_0000);
    wr(TCP_IRQEN, 32'h0000_0002);
    em = '{0, 0, 0, 0, 0, 0, 0, 0, 8};
    measure(8);
    wr(TCP_STATUS, 32'h0000_000D);
    em[8] = 0;
    measure(8);
    rd(TCP_STATUS, 32'h0000_000D, "flags");
    wr(TCP_IRQEN, 32'h0000_0000);
    // Edge-aligned PWM, modes 1 and 2, boundary values then random compares.
    wr(TCP_CHMODE, 32'h0000_7676);
    wr(TCP_OUTCFG, 32'({4{6'b100000}}));
    wr(TCP_CTRL, 32'h0000_0021);
    for (int k = 0; k < 5; k++) begin
      for (int i = 0; i < 4; i++) begin
        c[i] = (k == 0) ? ((i == 1) ? 9 : (i == 2) ? 8 : 0) : $unsigned($random(seed)) % 10;
        em[i] = 2 * ((i % 2 == 1) ? 8 - hi1(c[i], 7) : hi1(c[i], 7));
      end
      set_cmp();
      repeat (16) @(posedge i_ref_clk);
      measure(16);
    end
    // Edge-aligned down counting, mode 1.
    wr(TCP_CHMODE, 32'h0000_6666);
    wr(TCP_CTRL, 32'h0000_0023);
    wr(TCP_EVENT, 32'h0000_0001);
    c = '{0, 3, 7, 9};
    set_cmp();
    repeat (16) @(posedge i_ref_clk);
    em = '{2, 8, 16, 16, 0, 0, 0, 0, 0};
    measure(16);
    // Dead time of two cycles, polarity, pulse suppression, complementary alone.
    wr(TCP_CTRL, 32'h0000_0021);
    wr(TCP_EVENT, 32'h0000_0001);
    wr(TCP_DEADTIME, 32'h0000_0002);
    act_low <= 4'h4;
    wr(TCP_OUTCFG, 32'({6'b001000, 6'b111000, 6'b101000, 6'b101000}));
    c = '{5, 1, 4, 4};
    set_cmp();
    repeat (16) @(posedge i_ref_clk);
    em = '{6, 0, 12, 0, 2, 10, 4, 8, 0};
    measure(16);
    // Master enable falls: idle levels reached through the dead time.
    wr(TCP_OUTCFG, 32'({6'b001000, 6'b111000, 6'b101000, 6'b101010}));
    wr(TCP_CTRL, 32'h0000_0001);
    repeat (16) @(posedge i_ref_clk);
    em = '{16, 0, 0, 0, 0, 0, 0, 0, 0};
    measure(16);
    // Compare preload on, then off.
    act_low <= 4'h0;
    wr(TCP_DEADTIME, 32'h0000_0000);
    wr(TCP_OUTCFG, 32'h0000_0020);
    wr(TCP_CTRL, 32'h0000_0021);
    wr(TCP_RELOAD, 32'h0000_00C8);
    for (int p = 0; p < 2; p++) begin
      wr(TCP_CHMODE, (p == 0) ? 32'h0000_000E : 32'h0000_0006);
      wr(TCP_CMP0, 32'h0000_0064);
      wr(TCP_EVENT, 32'h0000_0001);
      wr(TCP_CMP0, 32'h0000_0000);
      repeat (4) @(posedge i_ref_clk);
      em[0] = (p == 0) ? 40 : 0;
      measure(40);
    end
    wr(TCP_CHMODE, 32'h0000_000E);
    wr(TCP_EVENT, 32'h0000_0001);
    repeat (4) @(posedge i_ref_clk);
    em[0] = 0;
    measure(40);
    // Center-aligned counting: direction ownership, counter writes, down-only flags, forced reference.
    wr(TCP_CTRL, 32'h0000_0024);
    wr(TCP_COUNT, 32'h0000_00C8);
    rd(TCP_CTRL, 32'h0000_0026, "dir");
    wr(TCP_COUNT, 32'h0000_012C);
    wr(TCP_CTRL, 32'h0000_0024);
    rd(TCP_CTRL, 32'h0000_0026, "dir");
    wr(TCP_COUNT, 32'h0000_0000);
    rd(TCP_CTRL, 32'h0000_0024, "dir");
    wr(TCP_RELOAD, 32'h0000_0007);
    wr(TCP_CHMODE, 32'h0000_0005);
    wr(TCP_STATUS, 32'h0000_0000);
    wr(TCP_CTRL, 32'h0000_0025);
    em[0] = 16;
    measure(16);
    rd(TCP_STATUS, 32'h0000_000F, "flags");
    `TCP_CHK("overlap", 32'h0000_0000, ovl)
    give_verdict();
  end
endmodule : timer_compare_pwm_deadtime_tb_top
